//--- hdl/pixel_capture_cfg.svh
`ifndef PIXEL_CAPTURE_CFG_SVH
`define PIXEL_CAPTURE_CFG_SVH

// Register byte offsets.
`define CFG_CONTROL_OFFSET      12'h000
`define CFG_DESKEW_OFFSET       12'h004
`define CFG_STATUS_OFFSET       12'h008
`define CFG_PIXEL_OFFSET        12'h00c
`define CFG_ADDR_BITS           12

// Control register fields.
`define CFG_CTRL_BUS_WIDTH_BIT  0
`define CFG_CTRL_STYLE_BIT      1
`define CFG_CTRL_EDGE_BIT       2
`define CFG_CTRL_RESET          3'h0

// De-skew register fields.
`define CFG_DK_ENABLE_BIT       3
`define CFG_DK_CODE_LSB         0
`define CFG_DK_RESET            4'h0

// Step code zero point and default step used when de-skew is disabled.
`define CFG_DK_CENTER           3'h4
`define CFG_DK_DEFAULT_CODE     3'h4

// De-skew increment: one sample of the local clock, expressed in ns.
`define CFG_DK_STEP_NS          4
`define CFG_CLK_PERIOD_NS       4
`define CFG_DK_STEP_CYCLES      ((`CFG_DK_STEP_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)

// Depth of the sample history line; holds the centre tap, four steps early and three late.
`define CFG_HISTORY_DEPTH       8

`endif

//--- hdl/pixel_capture_pkg.sv
package pixel_capture_pkg;

    typedef enum logic [2:0] {
        HALF_IDLE = 3'b001,
        HALF_LOW  = 3'b010,
        HALF_HIGH = 3'b100
    } half_state_type;

    typedef enum logic [1:0] {
        AHB_IDLE   = 2'b00,
        AHB_NONSEQ = 2'b10
    } ahb_trans_type;

endpackage

//--- hdl/sample_delay_line.sv
`timescale 1ns/1ps
`default_nettype none

// Shift line of past input samples; any tap can be picked each cycle.
module sample_delay_line #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 8
) (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic [WIDTH-1:0]         sample_in,
    input  wire logic [$clog2(DEPTH)-1:0] tap_select,
    output logic      [WIDTH-1:0]         tap_out
);

    logic [WIDTH-1:0] line_reg  [DEPTH];
    logic [WIDTH-1:0] line_next [DEPTH];

    always_comb begin
        line_next[0] = sample_in;
        for (int i = 1; i < DEPTH; i++) begin
            line_next[i] = line_reg[i-1];
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!reset_n) begin
                line_reg[i] <= '0;
            end else begin
                line_reg[i] <= line_next[i];
            end
        end
    end

    assign tap_out = line_reg[tap_select];

endmodule

`default_nettype wire

//--- hdl/pixel_input_capture_deskew.sv
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pixel_capture_cfg.svh"

module pixel_input_capture_deskew (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Configuration straps and host port select.
    input  wire logic        host_port_select,
    input  wire logic        low_swing,
    input  wire logic        strap_bus_width_select,
    input  wire logic        strap_clock_input_style_select,
    input  wire logic        strap_latch_edge_select,
    input  wire logic        strap_deskew_enable,
    input  wire logic [2:0]  strap_deskew_step_code,
    // Pixel link.
    input  wire logic        pixel_input_clock,
    input  wire logic [23:0] pixel_data,
    input  wire logic        active_video_flag,
    input  wire logic        hsync,
    input  wire logic        vsync,
    // Captured pixel output.
    output logic      [7:0]  red,
    output logic      [7:0]  green,
    output logic      [7:0]  blue,
    output logic             pixel_active_video,
    output logic             pixel_hsync,
    output logic             pixel_vsync,
    output logic             pixel_valid,
    output logic             clock_differential
);

    localparam int HIST_DEPTH = `CFG_HISTORY_DEPTH;
    localparam int TAP_BITS   = $clog2(HIST_DEPTH);
    localparam int LINK_WIDTH = 27;

    // =====================================================================
    // Pin synchronisers
    // =====================================================================
    // Every link and strap pin is outside the clk domain; two flops before any logic.
    logic [LINK_WIDTH:0] link_meta_reg;
    logic [LINK_WIDTH:0] link_sync_reg;
    logic [10:0]         strap_meta_reg;
    logic [10:0]         strap_sync_reg;
    logic [LINK_WIDTH:0] link_pins;
    logic [10:0]         strap_pins;

    assign link_pins  = {pixel_input_clock, vsync, hsync, active_video_flag, pixel_data};
    assign strap_pins = {host_port_select, low_swing, strap_bus_width_select,
                         strap_clock_input_style_select, strap_latch_edge_select,
                         strap_deskew_enable, strap_deskew_step_code, 2'h0};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            link_meta_reg  <= '0;
            link_sync_reg  <= '0;
            strap_meta_reg <= '0;
            strap_sync_reg <= '0;
        end else begin
            link_meta_reg  <= link_pins;
            link_sync_reg  <= link_meta_reg;
            strap_meta_reg <= strap_pins;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    logic       host_sel;
    logic       low_swing_s;
    logic       clk_level;
    logic [26:0] link_sample;

    assign host_sel    = strap_sync_reg[10];
    assign low_swing_s = strap_sync_reg[9];
    assign clk_level   = link_sync_reg[LINK_WIDTH];
    assign link_sample = link_sync_reg[LINK_WIDTH-1:0];

    // =====================================================================
    // AHB-Lite register slave
    // =====================================================================
    logic [2:0]  control_reg;
    logic [2:0]  control_next;
    logic [3:0]  deskew_reg;
    logic [3:0]  deskew_next;
    logic        wr_pend_reg;
    logic        wr_pend_next;
    logic [`CFG_ADDR_BITS-1:0] wr_addr_reg;
    logic [`CFG_ADDR_BITS-1:0] wr_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic        addr_phase;
    logic [31:0] status_word;

    assign addr_phase = hsel && hready && (htrans == pixel_capture_pkg::AHB_NONSEQ);

    always_comb begin
        control_next = control_reg;
        deskew_next  = deskew_reg;
        wr_pend_next = addr_phase && hwrite;
        wr_addr_next = addr_phase ? haddr[`CFG_ADDR_BITS-1:0] : wr_addr_reg;
        hrdata_next  = hrdata_reg;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `CFG_CONTROL_OFFSET: control_next = hwdata[2:0];
                `CFG_DESKEW_OFFSET:  deskew_next  = hwdata[3:0];
                default: ;
            endcase
        end
        if (addr_phase && !hwrite) begin
            case (haddr[`CFG_ADDR_BITS-1:0])
                `CFG_CONTROL_OFFSET: hrdata_next = {29'h0, control_reg};
                `CFG_DESKEW_OFFSET:  hrdata_next = {28'h0, deskew_reg};
                `CFG_STATUS_OFFSET:  hrdata_next = status_word;
                `CFG_PIXEL_OFFSET:   hrdata_next = {8'h0, red, green, blue};
                default:             hrdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            control_reg <= `CFG_CTRL_RESET;
            deskew_reg  <= `CFG_DK_RESET;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata_reg  <= 32'h0;
        end else begin
            control_reg <= control_next;
            deskew_reg  <= deskew_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg  <= hrdata_next;
        end
    end

    // Zero wait states; every access completes OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // =====================================================================
    // Mode selection
    // =====================================================================
    logic       bus_width_select;
    logic       clock_input_style_select;
    logic       latch_edge_select;
    logic       deskew_enable;
    logic [2:0] deskew_step_code;
    logic       diff_mode;

    always_comb begin
        if (host_sel) begin
            bus_width_select         = control_reg[`CFG_CTRL_BUS_WIDTH_BIT];
            clock_input_style_select = control_reg[`CFG_CTRL_STYLE_BIT];
            latch_edge_select        = control_reg[`CFG_CTRL_EDGE_BIT];
        end else begin
            bus_width_select         = strap_sync_reg[8];
            clock_input_style_select = strap_sync_reg[7];
            latch_edge_select        = strap_sync_reg[6];
        end
        if (host_sel) begin
            deskew_enable    = deskew_reg[`CFG_DK_ENABLE_BIT];
            deskew_step_code = deskew_reg[2:0];
        end else begin
            deskew_enable    = strap_sync_reg[5];
            deskew_step_code = strap_sync_reg[4:2];
        end
        // clock style decode; high swing forces single-ended.
        diff_mode = low_swing_s && (clock_input_style_select ^ ~bus_width_select);
    end

    assign clock_differential = diff_mode;
    assign status_word = {25'h0, pixel_valid, diff_mode, low_swing_s, host_sel,
                          latch_edge_select, bus_width_select, deskew_enable};

    // =====================================================================
    // Edge detection and de-skew
    // =====================================================================
    // the clock only feeds edge detection and never passes through the history line.
    // Edges are acted on three samples late, so the history line already holds
    // data from after the edge; code 4 then picks the last sample before it.
    logic [3:0] clk_pipe_reg;
    logic       rise_evt;
    logic       fall_evt;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clk_pipe_reg <= 4'h0;
        end else begin
            clk_pipe_reg <= {clk_pipe_reg[2:0], clk_level};
        end
    end

    assign rise_evt = clk_pipe_reg[2] && !clk_pipe_reg[3];
    assign fall_evt = !clk_pipe_reg[2] && clk_pipe_reg[3];

    // The late edge lets early and late shifts both stay causal.
    logic [2:0]          applied_code;
    logic [TAP_BITS-1:0] tap_select;
    logic [26:0]         deskewed_sample;

    assign applied_code = deskew_enable ? deskew_step_code : `CFG_DK_DEFAULT_CODE;
    // tap = centre minus (code - 4) steps; code 0 earliest.
    assign tap_select = TAP_BITS'((7 - int'(applied_code)) * `CFG_DK_STEP_CYCLES);

    // data and controls share the same shifted sampler.
    sample_delay_line #(
        .WIDTH (LINK_WIDTH),
        .DEPTH (HIST_DEPTH)
    ) u_history (
        .clk        (clk),
        .reset_n    (reset_n),
        .sample_in  (link_sample),
        .tap_select (tap_select),
        .tap_out    (deskewed_sample)
    );

    // =====================================================================
    // Capture and pixel assembly
    // =====================================================================
    logic primary_evt;
    logic second_evt;

    assign primary_evt = latch_edge_select ? rise_evt : fall_evt;
    assign second_evt  = latch_edge_select ? fall_evt : rise_evt;

    pixel_capture_pkg::half_state_type half_reg;
    pixel_capture_pkg::half_state_type half_next;
    logic [14:0] low_half_reg;
    logic [14:0] low_half_next;
    logic [23:0] rgb_reg;
    logic [23:0] rgb_next;
    logic [2:0]  ctl_reg;
    logic [2:0]  ctl_next;
    logic        valid_reg;
    logic        valid_next;

    always_comb begin
        half_next     = half_reg;
        low_half_next = low_half_reg;
        rgb_next      = rgb_reg;
        ctl_next      = ctl_reg;
        valid_next    = 1'b0;
        // both bus widths work with either latch edge, so all four width/edge pairings exist.
        if (bus_width_select) begin
            half_next = pixel_capture_pkg::HALF_IDLE;
            if (primary_evt) begin
                rgb_next   = deskewed_sample[23:0];
                ctl_next   = deskewed_sample[26:24];
                valid_next = 1'b1;
            end
        end else begin
            case (half_reg)
                pixel_capture_pkg::HALF_IDLE,
                pixel_capture_pkg::HALF_HIGH: begin
                    // low half on primary edge
                    // Controls wait with the low half, so outputs only change with valid.
                    if (primary_evt) begin
                        low_half_next = {deskewed_sample[26:24], deskewed_sample[11:0]};
                        half_next     = pixel_capture_pkg::HALF_LOW;
                    end
                end
                pixel_capture_pkg::HALF_LOW: begin
                    if (second_evt) begin
                        // red, green, blue from the two halves
                        rgb_next   = {deskewed_sample[11:0], low_half_reg[11:0]};
                        ctl_next   = low_half_reg[14:12];
                        valid_next = 1'b1;
                        half_next  = pixel_capture_pkg::HALF_HIGH;
                    end
                end
                default: half_next = pixel_capture_pkg::HALF_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            half_reg     <= pixel_capture_pkg::HALF_IDLE;
            low_half_reg <= 15'h0000;
            rgb_reg      <= 24'h000000;
            ctl_reg      <= 3'h0;
            valid_reg    <= 1'b0;
        end else begin
            half_reg     <= half_next;
            low_half_reg <= low_half_next;
            rgb_reg      <= rgb_next;
            ctl_reg      <= ctl_next;
            valid_reg    <= valid_next;
        end
    end

    assign red                = rgb_reg[23:16];
    assign green              = rgb_reg[15:8];
    assign blue               = rgb_reg[7:0];
    assign pixel_active_video = ctl_reg[0];
    assign pixel_hsync        = ctl_reg[1];
    assign pixel_vsync        = ctl_reg[2];
    assign pixel_valid        = valid_reg;

endmodule

`default_nettype wire

//--- dv/capture_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module capture_checker (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       host_port_select,
    input wire logic       low_swing,
    input wire logic       strap_bus_width_select,
    input wire logic       strap_clock_input_style_select,
    input wire logic       pixel_input_clock,
    input wire logic [7:0] red,
    input wire logic [7:0] green,
    input wire logic [7:0] blue,
    input wire logic       pixel_active_video,
    input wire logic       pixel_hsync,
    input wire logic       pixel_vsync,
    input wire logic       pixel_valid,
    input wire logic       clock_differential
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic strap_low;
    logic narrow;
    logic style;
    assign strap_low = !host_port_select && low_swing;
    assign narrow = !strap_bus_width_select;
    assign style = strap_clock_input_style_select;

    // =========================================
    // Clock style decode, given straps settle for six cycles.
    a_diff_high_swing: assert property (!low_swing [*6] |-> !clock_differential)
        else $error("differential clock in high swing");
    a_diff_narrow_zero: assert property ((strap_low && narrow && !style) [*6] |-> clock_differential)
        else $error("narrow style zero not differential");
    a_diff_narrow_one: assert property ((strap_low && narrow && style) [*6] |-> !clock_differential)
        else $error("narrow style one not single ended");
    a_diff_wide_zero: assert property ((strap_low && !narrow && !style) [*6] |-> !clock_differential)
        else $error("wide style zero not single ended");
    a_diff_wide_one: assert property ((strap_low && !narrow && style) [*6] |-> clock_differential)
        else $error("wide style one not differential");

    // =========================================
    // Pixel output timing.
    a_valid_gap: assert property (pixel_valid |=> !pixel_valid [*6])
        else $error("pixel valid too close together");
    a_valid_cause: assert property ($stable(pixel_input_clock) [*8] |-> !pixel_valid)
        else $error("pixel valid without a link edge");
    a_outputs_hold: assert property ($changed({red, green, blue, pixel_active_video, pixel_hsync,
        pixel_vsync}) |-> pixel_valid)
        else $error("pixel outputs changed without valid");
endmodule

`default_nettype wire

//--- dv/pixel_source.sv
`timescale 1ns/1ps
`default_nettype none

module pixel_source (
    output logic        link_clk,
    output logic [23:0] data,
    output logic [2:0]  ctl
);
    initial begin
        link_clk = 1'b0;
        data = 24'h000000;
        ctl = 3'h0;
    end

    // =========================================
    // One pixel per frame; the clock stands still between frames.
    task automatic send(input logic [23:0] early, input logic [23:0] word, input logic [2:0] c,
                        input logic twelve, input logic rising);
        if (link_clk == rising) begin
            link_clk = ~rising;
            data = ~data;
            #40;
        end
        data = early;
        ctl = c;
        #16;
        data = word;
        #14;
        link_clk = rising;
        #10;
        data = twelve ? {word[11:0], word[23:12]} : ~word;
        ctl = ~c;
        // Opposite edge one half period of the 32 ns link clock after the primary.
        #6;
        link_clk = ~rising;
        #12;
        // Released lines flip so a stale sample cannot pass.
        data = ~data;
        ctl = c;
    endtask
endmodule

`default_nettype wire

//--- dv/pixel_input_capture_deskew_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pixel_capture_cfg.svh"

module pixel_input_capture_deskew_tb;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = pixel_capture_pkg::AHB_IDLE;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        host_sel = 1'b0;
    logic        low_swing = 1'b0;
    logic        s_width = 1'b1;
    logic        s_style = 1'b0;
    logic        s_edge = 1'b1;
    logic        s_dk_en = 1'b0;
    logic [2:0]  s_dk_code = 3'h0;
    logic        link_clk;
    logic [23:0] data;
    logic [2:0]  ctl;
    logic [7:0]  red;
    logic [7:0]  green;
    logic [7:0]  blue;
    logic [2:0]  oc;
    logic        pixel_valid;
    logic        diff;
    logic [26:0] got;
    logic [23:0] pat [4] = '{24'h3c5a96, 24'hc3a569, 24'h12f0e8, 24'hed0f17};
    int          vcnt = 0;
    int          fail_count = 0;
    int          total_checks = 0;

    always #2 clk = ~clk;

    pixel_input_capture_deskew u_dut (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .host_port_select(host_sel), .low_swing(low_swing), .strap_bus_width_select(s_width),
        .strap_clock_input_style_select(s_style), .strap_latch_edge_select(s_edge),
        .strap_deskew_enable(s_dk_en), .strap_deskew_step_code(s_dk_code), .pixel_input_clock(link_clk),
        .pixel_data(data), .active_video_flag(ctl[0]), .hsync(ctl[1]), .vsync(ctl[2]), .red(red),
        .green(green), .blue(blue), .pixel_active_video(oc[0]), .pixel_hsync(oc[1]), .pixel_vsync(oc[2]),
        .pixel_valid(pixel_valid), .clock_differential(diff)
    );

    pixel_source u_src (.link_clk(link_clk), .data(data), .ctl(ctl));

    always @(posedge clk) begin
        if (pixel_valid === 1'b1) begin
            got <= {oc, red, green, blue};
            vcnt <= vcnt + 1;
        end
    end

    // =========================================
    // Shared tasks.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            fail_count++;
            print_verdict();
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= pixel_capture_pkg::AHB_NONSEQ;
        haddr <= {20'h00000, a};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= pixel_capture_pkg::AHB_IDLE;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask

    task automatic px(input logic [23:0] e, input logic [23:0] w, input logic twelve, input logic rising,
                      output logic [26:0] seen);
        int n0;
        int n;
        @(posedge clk);
        n0 = vcnt;
        #1;
        u_src.send(e, w, 3'h5, twelve, rising);
        n = 0;
        while (vcnt == n0 && n < 32) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        #1;
        check("pixel count", 32'(vcnt - n0), 32'h1);
        seen = got;
        if (n >= 32) begin
            print_verdict();
        end
    endtask

    // =========================================
    // Scenarios.
    task automatic reg_reset();
        rd_chk("control", `CFG_CONTROL_OFFSET, 32'h0);
        rd_chk("deskew", `CFG_DESKEW_OFFSET, 32'h0);
        wr(12'h010, 32'hffffffff);
        rd_chk("unmapped", 12'h010, 32'h0);
    endtask

    task automatic pixel_map();
        logic [26:0] s;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            s_width <= ~i[1];
            s_edge <= i[0];
            px(pat[i], pat[i], i[1], i[0], s);
            check("pixel", {5'h0, s}, {8'h05, pat[i]});
        end
        rd_chk("pixel reg", `CFG_PIXEL_OFFSET, {8'h0, pat[3]});
    endtask

    task automatic clock_style();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            low_swing <= i[2];
            s_width <= i[1];
            s_style <= i[0];
            repeat (8) @(posedge clk);
            #1;
            check("differential", {31'h0, diff}, {31'h0, i[2] && (i[1] == i[0])});
        end
        wr(`CFG_CONTROL_OFFSET, 32'h5);
        @(posedge clk);
        host_sel <= 1'b1;
        s_dk_en <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check("register style", {31'h0, diff}, 32'h0);
        rd_chk("control", `CFG_CONTROL_OFFSET, 32'h5);
    endtask

    task automatic deskew();
        logic [26:0] s;
        @(posedge clk);
        low_swing <= 1'b0; // single-ended source; high swing forces single-ended in every width/style
        for (int c = 0; c < 8; c++) begin
            wr(`CFG_DESKEW_OFFSET, {28'h0, 1'b1, 3'(c)});
            rd_chk("deskew reg", `CFG_DESKEW_OFFSET, {28'h0, 1'b1, 3'(c)});
            px(24'h5a0ff0, 24'ha5f00f, 1'b0, 1'b1, s);
            check("deskewed word", {8'h0, s[23:0]}, c < 2 ? 32'h5a0ff0 : 32'ha5f00f);
        end
        wr(`CFG_DESKEW_OFFSET, 32'h0);
        px(24'h5a0ff0, 24'ha5f00f, 1'b0, 1'b1, s);
        check("default deskew", {8'h0, s[23:0]}, 32'ha5f00f);
        @(posedge clk);
        host_sel <= 1'b0;
        s_dk_en <= 1'b1;
        s_dk_code <= 3'h0;
        px(24'h5a0ff0, 24'ha5f00f, 1'b0, 1'b1, s);
        check("strap deskew", {8'h0, s[23:0]}, 32'h5a0ff0);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        reg_reset();
        pixel_map();
        clock_style();
        deskew();
        print_verdict();
    end
endmodule

bind pixel_input_capture_deskew capture_checker u_chk (
    .clk, .reset_n, .host_port_select, .low_swing, .strap_bus_width_select, .strap_clock_input_style_select,
    .pixel_input_clock, .red, .green, .blue, .pixel_active_video, .pixel_hsync, .pixel_vsync, .pixel_valid,
    .clock_differential
);

`default_nettype wire
